// ==== hdl/cctu_pkg.sv ====
// constants and types shared by the capture/compare unit
package cctu_pkg;
    localparam int CLK_NS   = 20;
    localparam int TICK_NS  = 400;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int CH_NUM   = 32;
    localparam int ARR_CH   = 16;
    localparam int TMR_NUM  = 4;
    localparam int SRC_NUM  = CH_NUM + TMR_NUM;
    localparam int DBL_SPAN = 8;
    localparam int NOOUT_LO = 24;
    localparam int NOOUT_HI = 27;

    // word indices; byte address is index times four
    localparam logic [6:0] IDX_VAL  = 7'h00;
    localparam logic [6:0] IDX_CFG  = 7'h20;
    localparam logic [6:0] IDX_ICR  = 7'h40;
    localparam logic [6:0] IDX_TCNT = 7'h64;
    localparam logic [6:0] IDX_TREL = 7'h68;
    localparam logic [6:0] IDX_TCTL = 7'h6C;
    localparam logic [6:0] IDX_END  = 7'h70;

    localparam logic        WAIT_RST = 1'h1;
    localparam logic [31:0] OE_N_RST = 32'hFFFFFFFF;

    typedef enum logic [2:0] {
        FN_OFF      = 3'h0,
        FN_CAP_RISE = 3'h1,
        FN_CAP_FALL = 3'h2,
        FN_CAP_BOTH = 3'h3,
        FN_CMP0     = 3'h4,
        FN_CMP1     = 3'h5,
        FN_CMP2     = 3'h6,
        FN_CMP3     = 3'h7
    } cctu_func_type;

    typedef enum logic [2:0] {
        CS_DIV1 = 3'h0,
        CS_DIV2 = 3'h1,
        CS_DIV4 = 3'h2,
        CS_DIV8 = 3'h3,
        CS_DIV16 = 3'h4,
        CS_DIV32 = 3'h5,
        CS_GT6  = 3'h6,
        CS_EXT  = 3'h7
    } cctu_csel_type;

    typedef struct packed {
        logic          dbl;
        logic          tsel;
        cctu_func_type func;
    } cctu_cfg_type;

    typedef struct packed {
        logic       req;
        logic       en;
        logic [3:0] prio;
    } cctu_icr_type;

    typedef struct packed {
        logic          run;
        cctu_csel_type csel;
    } cctu_tctl_type;

    typedef struct packed {
        logic [15:0] presc;
        logic [15:0] cnt;
        logic        step;
        logic        ovf;
    } cctu_tmr_type;

    typedef struct packed {
        logic [CH_NUM-1:0][15:0]        val;
        cctu_cfg_type [CH_NUM-1:0]      cfg;
        cctu_icr_type [SRC_NUM-1:0]     icr;
        logic [CH_NUM-1:0]              once;
        logic [CH_NUM-1:0]              pin;
        logic [CH_NUM-1:0]              oe_n;
        logic [SRC_NUM-1:0]             irq;
        logic [TMR_NUM-1:0][15:0]       reload;
        cctu_tctl_type [TMR_NUM-1:0]    tctl;
        logic                           waitreq;
        logic [31:0]                    rdata;
    } cctu_core_type;
endpackage

// ==== hdl/cctu_sync_edge.sv ====
// two-stage synchroniser with edge detection
module cctu_sync_edge #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] raw,
    output logic [W-1:0]      rise,
    output logic [W-1:0]      fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } sync_type;

    sync_type q;
    sync_type d;

    always_comb
    begin
        d    = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end

    assign rise = q.s2 & ~q.s3;
    assign fall = ~q.s2 & q.s3;
endmodule

// ==== hdl/cctu_timer.sv ====
// one 16-bit time base timer with prescaler and reload
module cctu_timer (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire cctu_pkg::cctu_tctl_type ctl,
    input  wire logic [15:0]            reload,
    input  wire logic                   wr,
    input  wire logic [15:0]            wdata,
    input  wire logic                   gt6_ovf,
    input  wire logic                   ext_edge,
    output logic [15:0]                 cnt,
    output logic                        step,
    output logic                        ovf
);
    cctu_pkg::cctu_tmr_type q;
    cctu_pkg::cctu_tmr_type d;
    logic                   tick;

    function automatic logic [15:0] div_limit(input logic [2:0] sel);
        return 16'((cctu_pkg::TICK_CYC << sel) - 1);
    endfunction

    always_comb
    begin
        d      = q;
        d.step = 1'b0;
        d.ovf  = 1'b0;
        tick   = 1'b0;
        case (ctl.csel)
            cctu_pkg::CS_GT6: tick = gt6_ovf; // RL5
            cctu_pkg::CS_EXT: tick = ext_edge; // RL6
            default:
            begin
                if (!ctl.run || q.presc == div_limit(ctl.csel))
                    d.presc = 16'h0000;
                else
                    d.presc = q.presc + 16'h0001;
                tick = ctl.run && q.presc == div_limit(ctl.csel); // RL3
            end
        endcase
        if (wr)
            d.cnt = wdata;
        else if (ctl.run && tick)
        begin
            d.step = 1'b1;
            if (q.cnt == 16'hFFFF)
            begin
                d.cnt = reload; // RL19
                d.ovf = 1'b1;
            end
            else
                d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end

    assign cnt  = q.cnt;
    assign step = q.step;
    assign ovf  = q.ovf;
endmodule

// ==== hdl/cctu_top.sv ====
// capture/compare unit top with avalon register slave
//
// Behaviour
// RL1 - thirty-two capture/compare channels
// RL2 - two arrays of sixteen dual-purpose registers
// RL3 - finest tick 400 ns
// RL4 - four 16-bit reloading timers, two time bases
// RL5 - timer clock: prescaled clock or timer-six overflow
// RL6 - primary timers accept external count input
// RL7 - per channel timer choice and function
// RL8 - one pin per channel, 24-27 input only
// RL9 - capture copies timer on pin event
// RL10 - each capture raises channel request
// RL11 - capture edge rising, falling or both
// RL12 - compare on every count, act on match
// RL13 - mode 0: request every match, pin untouched
// RL14 - mode 1: toggle pin every match
// RL15 - mode 2: one request per period
// RL16 - mode 3: high on match, low on overflow
// RL17 - double mode: two registers toggle one pin
// RL18 - per source request, enable and priority
// RL19 - overflow reloads timer and ends period
// RL20 - output latch holds level, low after reset
module cctu_top (
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    input  wire logic [8:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic [31:0]   cc_pin_in,
    output logic [31:0]        cc_pin_out,
    output logic [31:0]        cc_pin_oe_n,
    input  wire logic          ext_count_a_in,
    input  wire logic          ext_count_b_in,
    input  wire logic          general_timer_six_ovf,
    output logic [35:0]        irq_req
);
    cctu_pkg::cctu_core_type       q;
    cctu_pkg::cctu_core_type       d;
    logic [3:0][15:0]              tcnt;
    logic [3:0]                    tstep;
    logic [3:0]                    tovf;
    logic [3:0]                    tmr_wr;
    logic [15:0]                   tmr_wdata;
    logic [31:0]                   pin_rise;
    logic [31:0]                   pin_fall;
    logic [1:0]                    ext_rise;
    logic [6:0]                    idx;
    logic                          wr_en;
    logic [31:0]                   rview;
    logic [2:0]                    rgn;
    logic [31:0]                   wv;
    logic [31:0]                   hit_ch;
    logic [31:0]                   tog;
    logic [35:0]                   src_hit;
    cctu_pkg::cctu_func_type       f;
    logic [1:0]                    tk;
    logic                          own;
    logic                          partner;
    logic                          drive;

    function automatic logic [1:0] tmr_of(input int ch, input logic tsel);
        return {ch >= cctu_pkg::ARR_CH, tsel};
    endfunction

    // word index to register region, shared by reads and writes
    function automatic logic [2:0] region_of(input logic [6:0] w);
        logic [2:0] r;
        r = 3'h6;
        if (w < cctu_pkg::IDX_CFG)
            r = 3'h0;
        else if (w < cctu_pkg::IDX_ICR)
            r = 3'h1;
        else if (w < cctu_pkg::IDX_TCNT)
            r = 3'h2;
        else if (w < cctu_pkg::IDX_TREL)
            r = 3'h3;
        else if (w < cctu_pkg::IDX_TCTL)
            r = 3'h4;
        else if (w < cctu_pkg::IDX_END)
            r = 3'h5;
        return r;
    endfunction

    // lower channel of a double pair
    function automatic logic lower_half(input int ch);
        return (ch % cctu_pkg::ARR_CH) < cctu_pkg::DBL_SPAN;
    endfunction

    function automatic logic cap_edge(input cctu_pkg::cctu_func_type fn, input logic up,
                                      input logic dn);
        return (up && (fn == cctu_pkg::FN_CAP_RISE || fn == cctu_pkg::FN_CAP_BOTH))
            || (dn && (fn == cctu_pkg::FN_CAP_FALL || fn == cctu_pkg::FN_CAP_BOTH));
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[b*8 +: 8] = wd[b*8 +: 8];
        return r;
    endfunction

    cctu_sync_edge #(.W(32)) u_pin_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .raw      (cc_pin_in),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    cctu_sync_edge #(.W(2)) u_ext_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .raw      ({ext_count_b_in, ext_count_a_in}),
        .rise     (ext_rise),
        .fall     ()
    );

    for (genvar t = 0; t < cctu_pkg::TMR_NUM; t++)
    begin : g_tmr
        // RL4
        cctu_timer u_tmr (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .ctl      (q.tctl[t]),
            .reload   (q.reload[t]),
            .wr       (tmr_wr[t]),
            .wdata    (tmr_wdata),
            .gt6_ovf  (general_timer_six_ovf),
            .ext_edge ((t % 2 == 0) ? ext_rise[t / 2] : 1'b0), // RL6
            .cnt      (tcnt[t]),
            .step     (tstep[t]),
            .ovf      (tovf[t])
        );
    end

    always_comb
    begin
        d         = q;
        idx       = avs_address[8:2];
        wr_en     = avs_write && !q.waitreq;
        tmr_wr    = 4'h0;
        hit_ch    = 32'h00000000;
        tog       = 32'h00000000;
        f         = cctu_pkg::FN_OFF;
        tk        = 2'h0;
        own       = 1'b0;
        partner   = 1'b0;
        drive     = 1'b0;

        // register view for reads and partial writes
        rgn   = region_of(idx);
        rview = 32'h00000000;
        case (rgn)
            3'h0:
                rview = 32'(q.val[idx[4:0]]);
            3'h1:
                rview = 32'(q.cfg[idx[4:0]]);
            3'h2:
                rview = 32'(q.icr[6'(idx - cctu_pkg::IDX_ICR)]);
            3'h3:
                rview = 32'(tcnt[idx[1:0]]);
            3'h4:
                rview = 32'(q.reload[idx[1:0]]);
            3'h5:
                rview = 32'(q.tctl[idx[1:0]]);
            default:
                rview = 32'h00000000;
        endcase
        wv        = merge(rview, avs_writedata, avs_byteenable);
        tmr_wdata = wv[15:0];

        // one wait state, then the answer
        d.waitreq = 1'b1;
        if ((avs_read || avs_write) && q.waitreq)
        begin
            d.waitreq = 1'b0;
            d.rdata   = rview;
        end

        // register writes
        if (wr_en)
        begin
            case (rgn)
                3'h0:
                    d.val[idx[4:0]] = wv[15:0];
                3'h1:
                    d.cfg[idx[4:0]] = cctu_pkg::cctu_cfg_type'(wv[4:0]); // RL7
                3'h2:
                    d.icr[6'(idx - cctu_pkg::IDX_ICR)] = cctu_pkg::cctu_icr_type'(wv[5:0]);
                3'h3:
                    tmr_wr[idx[1:0]] = 1'b1;
                3'h4:
                    d.reload[idx[1:0]] = wv[15:0];
                3'h5:
                    d.tctl[idx[1:0]] = cctu_pkg::cctu_tctl_type'(wv[3:0]); // RL5
                default:
                    tmr_wr = 4'h0;
            endcase
        end

        // channel events
        for (int i = 0; i < cctu_pkg::CH_NUM; i++) // RL1
        begin
            f  = q.cfg[i].func;
            tk = tmr_of(i, q.cfg[i].tsel); // RL2
            if (cap_edge(f, pin_rise[i], pin_fall[i])) // RL11
            begin
                d.val[i]  = tcnt[tk]; // RL9
                hit_ch[i] = 1'b1; // RL10
            end
            if (f >= cctu_pkg::FN_CMP0)
            begin
                if (tovf[tk])
                begin
                    d.once[i] = 1'b0; // RL19
                    if (f == cctu_pkg::FN_CMP3)
                        d.pin[i] = 1'b0; // RL16
                end
                if (tstep[tk] && q.val[i] == tcnt[tk]) // RL12
                begin
                    case (f)
                        cctu_pkg::FN_CMP0:
                            hit_ch[i] = 1'b1; // RL13
                        cctu_pkg::FN_CMP1:
                        begin
                            hit_ch[i] = 1'b1;
                            tog[i]    = 1'b1; // RL14
                        end
                        cctu_pkg::FN_CMP2,
                        cctu_pkg::FN_CMP3:
                        begin
                            if (!d.once[i])
                            begin
                                hit_ch[i] = 1'b1; // RL15
                                d.once[i] = 1'b1;
                                if (f == cctu_pkg::FN_CMP3)
                                    d.pin[i] = 1'b1; // RL16
                            end
                        end
                        default:
                            hit_ch[i] = 1'b0;
                    endcase
                end
            end
        end

        // pin latches and drive enables
        for (int i = 0; i < cctu_pkg::CH_NUM; i++)
        begin
            f       = q.cfg[i].func;
            own     = lower_half(i) && q.cfg[i].dbl;
            partner = !lower_half(i)
                      && q.cfg[(i + cctu_pkg::CH_NUM - cctu_pkg::DBL_SPAN)
                      % cctu_pkg::CH_NUM].dbl;
            if (own)
                d.pin[i] = d.pin[i] ^ (tog[i]
                           | tog[(i + cctu_pkg::DBL_SPAN) % cctu_pkg::CH_NUM]); // RL17
            else if (!partner)
                d.pin[i] = d.pin[i] ^ tog[i]; // RL20
            drive = !partner && (own || f == cctu_pkg::FN_CMP1 || f == cctu_pkg::FN_CMP3);
            if (i >= cctu_pkg::NOOUT_LO && i <= cctu_pkg::NOOUT_HI)
            begin
                drive    = 1'b0; // RL8
                d.pin[i] = 1'b0;
            end
            d.oe_n[i] = !drive; // RL8
        end

        // request flags, hardware set wins over software clear
        src_hit = {tovf, hit_ch};
        for (int s = 0; s < cctu_pkg::SRC_NUM; s++)
        begin
            if (src_hit[s])
                d.icr[s].req = 1'b1; // RL18
            d.irq[s] = d.icr[s].req && d.icr[s].en; // RL18
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            q         <= '0; // RL20
            q.oe_n    <= cctu_pkg::OE_N_RST;
            q.waitreq <= cctu_pkg::WAIT_RST;
        end
        else
            q <= d;
    end

    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign cc_pin_out      = q.pin;
    assign cc_pin_oe_n     = q.oe_n;
    assign irq_req         = q.irq;
endmodule

// ==== sim/capture_compare_timer_unit_test.sv ====
// self-checking bench for the capture/compare unit
module capture_compare_timer_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [8:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [2:0]  src;
    logic [31:0] avs_writedata, avs_readdata, pin_out, oe_n, pin_lvl, drv, rd;
    logic [35:0] irq_req;
    logic [31:0] v [32];
    logic [15:0] tv [4];
    int          n_fail, n_checks, seed, c, t, f, r, tg [32];

    cctu_top i_dut (
        .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .cc_pin_in(pin_lvl),
        .cc_pin_out(pin_out), .cc_pin_oe_n(oe_n), .ext_count_a_in(src[0]),
        .ext_count_b_in(src[1]), .general_timer_six_ovf(src[2]), .irq_req
    );
    cctu_pins_model i_pins (
        .core_clk, .drive_val(drv), .cc_pin_out(pin_out), .cc_pin_oe_n(oe_n),
        .pin_level(pin_lvl)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic int tmr_for(input int ch, input int sel);
        return 2 * (ch / 16) + sel;
    endfunction

    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= {a, 2'h0};
        avs_writedata <= d;
        for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++)
            @(posedge core_clk);
        n_fail += (i == 20);
        if (i == 20)
            summarize();
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic pulse(input int b, input int n, input int h);
        repeat (n)
        begin
            src[b] <= 1'b1;
            repeat (h) @(posedge core_clk);
            src[b] <= 1'b0;
            repeat (h) @(posedge core_clk);
        end
    endtask

    task automatic rst();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(pin_out, 32'h0);
        chk(oe_n, cctu_pkg::OE_N_RST);
        chk(irq_req[31:0] | irq_req[35:32], 32'h0);
        $display("reset test done");
    endtask

    initial
    begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        summarize();
    end

    initial
    begin
        seed = 99826;
        sys_rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, src, drv} = '0;
        avs_byteenable = 4'hF;
        n_fail = 0;
        n_checks = 0;
        rst();
        // register words, byte lanes, unmapped word
        for (c = 0; c < 32; c++)
        begin
            v[c] = $random(seed);
            bus(1, cctu_pkg::IDX_VAL + c[6:0], v[c]);
        end
        for (c = 0; c < 32; c++)
        begin
            bus(0, cctu_pkg::IDX_VAL + c[6:0], 0);
            chk(rd, {16'h0, v[c][15:0]});
        end
        avs_byteenable <= 4'h1;
        bus(1, cctu_pkg::IDX_VAL, 32'h0);
        avs_byteenable <= 4'hF;
        bus(0, cctu_pkg::IDX_VAL, 0);
        chk(rd, {16'h0, v[0][15:8], 8'h0});
        bus(1, 7'h70, 32'h5A);
        bus(0, 7'h70, 0);
        chk(rd, 32'h0);
        bus(1, cctu_pkg::IDX_CFG, v[1]);
        bus(0, cctu_pkg::IDX_CFG, 0);
        chk(rd, {27'h0, v[1][4:0]});
        bus(1, cctu_pkg::IDX_CFG, 0);
        $display("register test done");
        // count sources: external edges and timer-six pulses
        for (t = 0; t < 4; t++)
        begin
            bus(1, cctu_pkg::IDX_TCNT + t[6:0], 0);
            bus(1, cctu_pkg::IDX_TCTL + t[6:0], t[0] ? 32'hE : 32'hF);
            pulse(t[0] ? 2 : t[1], 5 + t, t[0] ? 1 : 3);
            bus(1, cctu_pkg::IDX_TCTL + t[6:0], 0);
            bus(0, cctu_pkg::IDX_TCNT + t[6:0], 0);
            chk(rd, 5 + t);
        end
        bus(1, cctu_pkg::IDX_TCNT, 0);
        bus(1, cctu_pkg::IDX_TCTL, 32'h8);
        repeat (400) @(posedge core_clk);
        bus(1, cctu_pkg::IDX_TCTL, 0);
        bus(0, cctu_pkg::IDX_TCNT, 0);
        chk(rd, 32'(400 / cctu_pkg::TICK_CYC));
        $display("count source test done");
        // capture on each edge kind, random channel and timer
        for (t = 0; t < 4; t++)
        begin
            tv[t] = $random(seed);
            bus(1, cctu_pkg::IDX_TCNT + t[6:0], tv[t]);
        end
        for (f = 1; f < 4; f++)
        begin
            c = {$random(seed)} % 32;
            t = {$random(seed)} % 2;
            bus(1, cctu_pkg::IDX_CFG + c[6:0], f + 8 * t);
            bus(1, cctu_pkg::IDX_ICR + c[6:0], 32'h13);
            bus(1, cctu_pkg::IDX_VAL + c[6:0], 0);
            drv[c] <= 1'b1;
            repeat (6) @(posedge core_clk);
            bus(0, cctu_pkg::IDX_ICR + c[6:0], 0);
            chk(rd, f == 2 ? 32'h13 : 32'h33);
            chk(irq_req[c], f != 2);
            bus(0, cctu_pkg::IDX_VAL + c[6:0], 0);
            chk(rd, f == 2 ? 0 : tv[tmr_for(c, t)]);
            bus(1, cctu_pkg::IDX_ICR + c[6:0], 32'h10);
            drv[c] <= 1'b0;
            repeat (6) @(posedge core_clk);
            chk(irq_req[c], f != 1);
            bus(1, cctu_pkg::IDX_CFG + c[6:0], 0);
        end
        $display("capture test done");
        // compare modes on both arrays over three timer periods
        for (f = 0; f < 2; f++)
        begin
            c = 16 * f;
            t = 2 * f;
            bus(1, cctu_pkg::IDX_TREL + t[6:0], 32'hFFF0);
            bus(1, cctu_pkg::IDX_TCNT + t[6:0], 32'hFFF0);
            for (r = 0; r < 13; r++)
            begin
                bus(1, cctu_pkg::IDX_CFG + c[6:0] + r[6:0], r > 4 ? 5 : r == 4 ? 32'h15 : 4 + r);
                bus(1, cctu_pkg::IDX_VAL + c[6:0] + r[6:0], r == 12 ? 32'hFFFA : 32'hFFF4);
            end
            bus(1, cctu_pkg::IDX_ICR + c[6:0], 32'h10);
            bus(1, cctu_pkg::IDX_ICR + c[6:0] + 7'h02, 32'h10);
            bus(1, cctu_pkg::IDX_ICR + 7'h20 + t[6:0], 32'h10);
            bus(1, cctu_pkg::IDX_TCTL + t[6:0], 32'h8);
            repeat (400) @(posedge core_clk);
            tg = i_pins.tgl;
            repeat (960) @(posedge core_clk);
            chk(i_pins.tgl[c] - tg[c], 0);
            chk(i_pins.tgl[c + 1] - tg[c + 1], 3);
            chk(i_pins.tgl[c + 2] - tg[c + 2], 0);
            chk(i_pins.tgl[c + 3] - tg[c + 3], 6);
            chk(i_pins.tgl[c + 4] - tg[c + 4], 6);
            chk(oe_n[c + 12], 1);
            chk(i_pins.tgl[c + 8] - tg[c + 8], f ? 0 : 3);
            chk(oe_n[c + 8], f);
            chk({irq_req[c], irq_req[c + 2], irq_req[32 + t]}, 3'h7);
            bus(0, cctu_pkg::IDX_TCNT + t[6:0], 0);
            chk(rd >= 32'hFFF0 && rd <= 32'hFFFF, 1);
            // rewind within one period: mode 0 fires again, mode 2 does not
            for (r = 0; r < 2; r++)
            begin
                bus(1, cctu_pkg::IDX_TCTL + t[6:0], 0);
                bus(1, cctu_pkg::IDX_ICR + c[6:0], 32'h10);
                bus(1, cctu_pkg::IDX_ICR + c[6:0] + 7'h02, 32'h10);
                bus(1, cctu_pkg::IDX_TCNT + t[6:0], 32'hFFF3);
                bus(1, cctu_pkg::IDX_TCTL + t[6:0], 32'h8);
                repeat (50) @(posedge core_clk);
                bus(1, cctu_pkg::IDX_TCTL + t[6:0], 0);
            end
            chk({irq_req[c], irq_req[c + 2]}, 2'h2);
            $display("compare test done");
        end
        rst();
        summarize();
    end
endmodule

// ==== sim/cctu_pins_model.sv ====
// port pin model: resolves pin levels and counts driven toggles
module cctu_pins_model (
    input  wire logic        core_clk,
    input  wire logic [31:0] drive_val,
    input  wire logic [31:0] cc_pin_out,
    input  wire logic [31:0] cc_pin_oe_n,
    output logic [31:0]      pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    int          tgl [32];
    logic [31:0] last_q;
    // undriven pins follow the external driver
    assign pin_level = (cc_pin_out & ~cc_pin_oe_n) | (drive_val & cc_pin_oe_n);
    initial
        foreach (tgl[i])
            tgl[i] = 0;
    always @(posedge core_clk)
    begin
        for (int i = 0; i < 32; i++)
            if (!cc_pin_oe_n[i] && pin_level[i] !== last_q[i])
                tgl[i]++;
        last_q = pin_level;
    end
endmodule

// ==== sim/cctu_props.sv ====
// port checker for the capture/compare unit
module cctu_chk (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [8:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [31:0] cc_pin_out,
    input wire logic [31:0] cc_pin_oe_n,
    input wire logic [35:0] irq_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic       req;
    logic       rdq;
    logic [6:0] idx;
    assign req = (avs_read || avs_write) && avs_waitrequest;
    assign rdq = avs_read && avs_waitrequest;
    assign idx = avs_address[8:2];
    property p_rst;
        $fell(sys_rst) |-> cc_pin_out == 32'h0 && irq_req == 36'h0
            && cc_pin_oe_n == cctu_pkg::OE_N_RST;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_noout;
        cc_pin_oe_n[27:24] == 4'hF && cc_pin_out[27:24] == 4'h0;
    endproperty
    a_noout: assert property (p_noout) else $error("input-only pin driven");
    property p_ans;
        req |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("answer timing wrong");
    property p_idle;
        !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_hold;
        avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap;
        rdq && idx >= cctu_pkg::IDX_END |=> avs_readdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_val16;
        rdq && idx < cctu_pkg::IDX_CFG |=> avs_readdata[31:16] == 16'h0;
    endproperty
    a_val16: assert property (p_val16) else $error("channel word too wide");
    property p_tmr16;
        rdq && idx >= cctu_pkg::IDX_TCNT && idx < cctu_pkg::IDX_TCTL
            |=> avs_readdata[31:16] == 16'h0;
    endproperty
    a_tmr16: assert property (p_tmr16) else $error("timer word too wide");
    property p_cfg5;
        rdq && idx >= cctu_pkg::IDX_CFG && idx < cctu_pkg::IDX_ICR
            |=> avs_readdata[31:5] == 27'h0;
    endproperty
    a_cfg5: assert property (p_cfg5) else $error("config word too wide");
endmodule

bind cctu_top cctu_chk i_chk (
    .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .cc_pin_out, .cc_pin_oe_n, .irq_req
);
